// ==== verilog/pmsr_consts.vh ====
`ifndef PMSR_CONSTS_VH
`define PMSR_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets (15-bit serial address space)
// ---------------------------------------------------------------
`define PMSR_ADDR_W 15
`define PMSR_OFS_POWER_CONTROL 15'h0009
`define PMSR_OFS_POWER_DOWN_MASK 15'h000D
`define PMSR_OFS_SYNC_REF_CTRL 15'h000E
`define PMSR_OFS_INPUT_MODE 15'h0011

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PMSR_RST_POWER_CONTROL 8'h00
`define PMSR_RST_POWER_DOWN_MASK 8'h00
`define PMSR_RST_SYNC_REF_CTRL 8'h00
`define PMSR_RST_INPUT_MODE 8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PMSR_BIT_GLOBAL_OFF 0
`define PMSR_BIT_KEEP_BIAS 5
`define PMSR_BIT_KEEP_CLKBUF 3
`define PMSR_BIT_KEEP_REFAMP 2
`define PMSR_BIT_ALLOW_BG_OFF 1
`define PMSR_BIT_PIN_IS_SYNC 7
`define PMSR_BIT_REG_SYNC 6
`define PMSR_BIT_REG_SYNC_EN 5
`define PMSR_BIT_REF_BY_REG 3
`define PMSR_BIT_REF_SEL_HI 2
`define PMSR_BIT_REF_SEL_LO 1
`define PMSR_BIT_SE_CLOCK 0
`define PMSR_BIT_SE_ANALOG 5
`define PMSR_BIT_DELAY_LINE_OFF 2
`define PMSR_BIT_AUTO_ZERO 0

// ---------------------------------------------------------------
// Reference selection codes
// ---------------------------------------------------------------
`define PMSR_REF_INTERNAL 2'h0
`define PMSR_REF_EXT_BUFFERED 2'h1
`define PMSR_REF_EXT_DIRECT 2'h2

// ---------------------------------------------------------------
// Serial frame layout
// ---------------------------------------------------------------
`define PMSR_FRAME_BITS 5'h18
`define PMSR_DATA_START 5'h10
`define PMSR_CNT_W 5

`endif

// ==== verilog/pmsr_ctrl.v ====
`include "pmsr_consts.vh"

// Overview of operation
// RQ1: Bias mask set keeps bias on
// RQ2: Clock buffer mask set keeps buffer on
// RQ3: Reference amp mask set keeps amp on
// RQ4: Bandgap mask set lets bandgap switch off
// RQ5: Pin-function bit chooses power-down or sync
// RQ6: Toggling register sync bit issues sync
// RQ7: Register sync bit never self-clears
// RQ8: Sync enable bit selects register over pin
// RQ9: Reference-by-register bit picks pin or fields
// RQ10: Reference field decodes internal, buffered, direct
// RQ11: Host sets reference-by-register for field effect
// RQ12: Single-ended clock bit powers down differential buffer
// RQ13: Input-mode fields at bits five, two, zero
// RQ14: Global power-off bit enters global power-down
// RQ15: Input-mode bit five selects single-ended input
// RQ16: Input-mode bit zero enables auto-zero
// RQ17: Host writes zero to reserved bits
// RQ18: Block power-downs combinational from request and mask
module pmsr_ctrl (
  input wire clock_i,
  input wire rst_b_i,
  input wire spi_sen_b_i,
  input wire spi_sclk_i,
  input wire spi_sdi_i,
  output wire spi_sdo_o,
  output wire spi_sdo_oe_o,
  input wire sync_or_power_down_pin_i,
  input wire reference_buffer_pin_i,
  output wire global_power_off_o,
  output wire bias_off_o,
  output wire clock_buffer_off_o,
  output wire diff_clock_buffer_off_o,
  output wire reference_amp_off_o,
  output wire bandgap_off_o,
  output wire sync_pulse_o,
  output wire ref_internal_o,
  output wire ref_ext_buffered_o,
  output wire ref_ext_direct_o,
  output wire single_ended_clock_select_o,
  output wire single_ended_analog_input_o,
  output wire delay_line_power_off_o,
  output wire auto_zero_enable_o
);

  // ---------------------------------------------------------------
  // Serial interface
  // ---------------------------------------------------------------
  reg sclk_q;
  reg pin_q;
  reg [`PMSR_CNT_W-1:0] cnt_q;
  reg [`PMSR_CNT_W-1:0] cnt_d;
  reg [22:0] shift_q;
  reg [22:0] shift_d;
  reg [7:0] out_q;
  reg [7:0] out_d;
  reg read_q;
  reg read_d;
  reg [7:0] power_control_q;
  reg [7:0] power_down_mask_q;
  reg [7:0] sync_and_reference_control_q;
  reg [7:0] input_mode_control_q;
  reg sync_q;
  reg sync_d;
  reg [7:0] rd_data;
  reg wr_en;
  wire sclk_rise;
  wire sclk_fall;
  wire [`PMSR_ADDR_W-1:0] rd_addr;
  wire [`PMSR_ADDR_W-1:0] wr_addr;
  wire [7:0] wr_data;
  wire pin_rise;
  wire [1:0] ref_code;
  wire ref_by_reg;
  wire wr_power_control;
  wire wr_power_down_mask;
  wire wr_sync_ref_ctrl;
  wire wr_input_mode;
  wire pin_is_sync;
  wire reg_sync_en;
  wire reg_sync_toggle;
  wire [3:0] keep_on;
  wire [3:0] block_off;
  genvar blk;

  // Pins are synchronous to clock_i, so edges come from one flop
  assign sclk_rise = spi_sclk_i & ~sclk_q & ~spi_sen_b_i;
  assign sclk_fall = ~spi_sclk_i & sclk_q & ~spi_sen_b_i;
  assign pin_rise = sync_or_power_down_pin_i & ~pin_q;

  // Read address completes with the bit taken at the 16th rise
  assign rd_addr = {shift_q[13:0], spi_sdi_i};
  // At the 24th rise the read flag sits just above the address
  assign wr_addr = shift_q[21:7];
  assign wr_data = {shift_q[6:0], spi_sdi_i};

  assign wr_power_control = wr_en &&
    (wr_addr == `PMSR_OFS_POWER_CONTROL);
  assign wr_power_down_mask = wr_en &&
    (wr_addr == `PMSR_OFS_POWER_DOWN_MASK);
  assign wr_sync_ref_ctrl = wr_en &&
    (wr_addr == `PMSR_OFS_SYNC_REF_CTRL);
  assign wr_input_mode = wr_en && (wr_addr == `PMSR_OFS_INPUT_MODE);

  // ---------------------------------------------------------------
  // Read mux; unmapped addresses return zero
  // ---------------------------------------------------------------
  always @* begin
    case (rd_addr)
      `PMSR_OFS_POWER_CONTROL: rd_data = power_control_q;
      `PMSR_OFS_POWER_DOWN_MASK: rd_data = power_down_mask_q;
      `PMSR_OFS_SYNC_REF_CTRL: rd_data = sync_and_reference_control_q;
      `PMSR_OFS_INPUT_MODE: rd_data = input_mode_control_q;
      default: rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Frame sequencing
  // ---------------------------------------------------------------
  always @* begin
    cnt_d = cnt_q;
    shift_d = shift_q;
    out_d = out_q;
    read_d = read_q;
    wr_en = 1'b0;
    if (spi_sen_b_i) begin
      cnt_d = {`PMSR_CNT_W{1'b0}};
      read_d = 1'b0;
    end else if (sclk_rise) begin
      shift_d = {shift_q[21:0], spi_sdi_i};
      if (cnt_q != `PMSR_FRAME_BITS) begin
        cnt_d = cnt_q + 1'b1;
      end
      if (cnt_q == {`PMSR_CNT_W{1'b0}}) begin
        read_d = spi_sdi_i;
      end
      // Data byte is driven from the 16th rising edge onward
      if (cnt_q == `PMSR_DATA_START - 1'b1) begin
        out_d = rd_data;
      end
      if ((cnt_q == `PMSR_FRAME_BITS - 1'b1) && !read_q) begin
        wr_en = 1'b1;
      end
    end else if (sclk_fall && (cnt_q > `PMSR_DATA_START)) begin
      // Shift only after the host sampled on the preceding rise
      out_d = {out_q[6:0], 1'b0};
    end
  end

  assign spi_sdo_o = out_q[7];
  assign spi_sdo_oe_o = read_q & ~spi_sen_b_i &
    (cnt_q >= `PMSR_DATA_START);

  // ---------------------------------------------------------------
  // Sync generation
  // ---------------------------------------------------------------
  assign pin_is_sync =
    sync_and_reference_control_q[`PMSR_BIT_PIN_IS_SYNC]; // RQ5
  // Enable judged on the value held before the write
  assign reg_sync_en =
    sync_and_reference_control_q[`PMSR_BIT_REG_SYNC_EN]; // RQ8
  // Register path: any write that changes the bit is a toggle
  assign reg_sync_toggle = wr_sync_ref_ctrl &&
    (wr_data[`PMSR_BIT_REG_SYNC] !=
     sync_and_reference_control_q[`PMSR_BIT_REG_SYNC]);

  always @* begin
    sync_d = 1'b0;
    if (reg_sync_toggle && reg_sync_en) begin
      sync_d = 1'b1; // RQ6
    end
    // Pin path only while register sync is not selected
    if (pin_rise && pin_is_sync && !reg_sync_en) begin
      sync_d = 1'b1; // RQ5 RQ8
    end
  end

  // ---------------------------------------------------------------
  // Serial interface registers
  // ---------------------------------------------------------------
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_q <= 1'b0;
      pin_q <= 1'b0;
      cnt_q <= {`PMSR_CNT_W{1'b0}};
      shift_q <= 23'h00_0000;
      out_q <= 8'h00;
      read_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk_i;
      pin_q <= sync_or_power_down_pin_i;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      out_q <= out_d;
      read_q <= read_d;
    end
  end

  // ---------------------------------------------------------------
  // Sync pulse register
  // ---------------------------------------------------------------
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign sync_pulse_o = sync_q;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Every bit, reserved ones included, stores as written
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_control_q <= `PMSR_RST_POWER_CONTROL;
    end else if (wr_power_control) begin
      power_control_q <= wr_data; // RQ14
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_down_mask_q <= `PMSR_RST_POWER_DOWN_MASK;
    end else if (wr_power_down_mask) begin
      power_down_mask_q <= wr_data; // RQ18
    end
  end

  // Sync bit holds its written value; no self-clear
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_and_reference_control_q <= `PMSR_RST_SYNC_REF_CTRL;
    end else if (wr_sync_ref_ctrl) begin
      sync_and_reference_control_q <= wr_data; // RQ7
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      input_mode_control_q <= `PMSR_RST_INPUT_MODE;
    end else if (wr_input_mode) begin
      input_mode_control_q <= wr_data; // RQ13
    end
  end

  // ---------------------------------------------------------------
  // Global power-down and masked block controls
  // ---------------------------------------------------------------
  assign global_power_off_o = power_control_q[`PMSR_BIT_GLOBAL_OFF] |
    (sync_or_power_down_pin_i &
     ~sync_and_reference_control_q[`PMSR_BIT_PIN_IS_SYNC]); // RQ14 RQ5

  // Combinational so a mask change acts without delay
  // Bandgap bit inverted: set trades wake-up time for lower power
  assign keep_on = {power_down_mask_q[`PMSR_BIT_KEEP_BIAS],
    power_down_mask_q[`PMSR_BIT_KEEP_CLKBUF],
    power_down_mask_q[`PMSR_BIT_KEEP_REFAMP],
    ~power_down_mask_q[`PMSR_BIT_ALLOW_BG_OFF]}; // RQ4
  generate
    for (blk = 0; blk < 4; blk = blk + 1) begin : g_block_off
      assign block_off[blk] = global_power_off_o & ~keep_on[blk]; // RQ18
    end
  endgenerate
  assign bias_off_o = block_off[3]; // RQ1
  assign clock_buffer_off_o = block_off[2]; // RQ2
  assign reference_amp_off_o = block_off[1]; // RQ3
  assign bandgap_off_o = block_off[0]; // RQ4

  // ---------------------------------------------------------------
  // Reference and clock selection
  // ---------------------------------------------------------------
  assign ref_by_reg =
    sync_and_reference_control_q[`PMSR_BIT_REF_BY_REG];
  // Pin low picks internal, pin high picks external via buffer
  assign ref_code = ref_by_reg ?
    sync_and_reference_control_q[`PMSR_BIT_REF_SEL_HI:
                                 `PMSR_BIT_REF_SEL_LO] :
    {1'b0, reference_buffer_pin_i}; // RQ9
  // Code 11 selects nothing
  assign ref_internal_o = (ref_code == `PMSR_REF_INTERNAL); // RQ10
  assign ref_ext_buffered_o = (ref_code == `PMSR_REF_EXT_BUFFERED); // RQ10
  assign ref_ext_direct_o = (ref_code == `PMSR_REF_EXT_DIRECT); // RQ10

  assign single_ended_clock_select_o = ref_by_reg &
    sync_and_reference_control_q[`PMSR_BIT_SE_CLOCK]; // RQ12
  assign diff_clock_buffer_off_o = clock_buffer_off_o |
    single_ended_clock_select_o; // RQ12

  // ---------------------------------------------------------------
  // Input mode
  // ---------------------------------------------------------------
  assign single_ended_analog_input_o =
    input_mode_control_q[`PMSR_BIT_SE_ANALOG]; // RQ15
  assign delay_line_power_off_o =
    input_mode_control_q[`PMSR_BIT_DELAY_LINE_OFF]; // RQ13
  assign auto_zero_enable_o =
    input_mode_control_q[`PMSR_BIT_AUTO_ZERO]; // RQ16

endmodule

// ==== sim/pmsr_ctrl_sva.sv ====
module pmsr_ctrl_sva (
  input wire clock_i,
  input wire rst_b_i,
  input wire spi_sen_b_i,
  input wire spi_sdo_oe_o,
  input wire global_power_off_o,
  input wire bias_off_o,
  input wire clock_buffer_off_o,
  input wire diff_clock_buffer_off_o,
  input wire reference_amp_off_o,
  input wire bandgap_off_o,
  input wire sync_pulse_o,
  input wire ref_internal_o,
  input wire ref_ext_buffered_o,
  input wire ref_ext_direct_o,
  input wire single_ended_clock_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_pulse; sync_pulse_o ##1 !sync_pulse_o; endsequence
  property p_bias; bias_off_o |-> global_power_off_o; endproperty
  property p_cbuf; clock_buffer_off_o |-> global_power_off_o; endproperty
  property p_ramp; reference_amp_off_o |-> global_power_off_o; endproperty
  property p_bg; bandgap_off_o |-> global_power_off_o; endproperty
  property p_diff; diff_clock_buffer_off_o ==
    (clock_buffer_off_o || single_ended_clock_select_o); endproperty
  property p_ref; $onehot0({ref_internal_o, ref_ext_buffered_o,
    ref_ext_direct_o}); endproperty
  property p_sync; $rose(sync_pulse_o) |-> s_pulse; endproperty
  property p_oe; (spi_sdo_oe_o && !spi_sen_b_i) |=>
    (spi_sdo_oe_o || spi_sen_b_i); endproperty
  a_bias: assert property (p_bias) else $error("bias off");
  a_cbuf: assert property (p_cbuf) else $error("clock buf off");
  a_ramp: assert property (p_ramp) else $error("ref amp off");
  a_bg: assert property (p_bg) else $error("bandgap off");
  a_diff: assert property (p_diff) else $error("diff buf");
  a_ref: assert property (p_ref) else $error("ref decode");
  a_sync: assert property (p_sync) else $error("sync width");
  a_oe: assert property (p_oe) else $error("sdo enable");
endmodule

bind pmsr_ctrl pmsr_ctrl_sva chk (.clock_i, .rst_b_i, .spi_sen_b_i,
  .spi_sdo_oe_o, .global_power_off_o, .bias_off_o, .clock_buffer_off_o,
  .diff_clock_buffer_off_o, .reference_amp_off_o, .bandgap_off_o,
  .sync_pulse_o, .ref_internal_o, .ref_ext_buffered_o, .ref_ext_direct_o,
  .single_ended_clock_select_o);

// ==== sim/pmsr_spi_host.sv ====
module pmsr_spi_host (
  input wire logic clock_i,
  input wire logic sdo_i,
  output logic sen_b_o,
  output logic sclk_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sen_b_o = 1;
    sclk_o = 0;
    sdi_o = 1;
  end
  // Two clocks a level so the oversampler never misses an edge
  task automatic xfer(input logic rd, input logic [14:0] adr,
                      input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] f;
    f = {rd, adr, wd};
    rdat = 8'h00;
    sen_b_o = 0;
    for (int k = 23; k >= 0; k--) begin
      sdi_o = f[k];
      repeat (2) @(negedge clock_i);
      if (k < 8) rdat[k] = sdo_i;
      sclk_o = 1;
      repeat (2) @(negedge clock_i);
      sclk_o = 0;
    end
    repeat (2) @(negedge clock_i);
    sen_b_o = 1;
    sdi_o = ~sdi_o;
    @(negedge clock_i);
  endtask
endmodule

// ==== sim/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, rst_b_i = 0, pin = 0, refpin = 0;
  wire spi_sen_b_i, spi_sclk_i, spi_sdi_i, spi_sdo_o, spi_sdo_oe_o;
  wire global_power_off_o, bias_off_o, clock_buffer_off_o, bandgap_off_o;
  wire diff_clock_buffer_off_o, reference_amp_off_o, sync_pulse_o;
  wire ref_internal_o, ref_ext_buffered_o, ref_ext_direct_o;
  wire single_ended_clock_select_o, single_ended_analog_input_o;
  wire delay_line_power_off_o, auto_zero_enable_o;
  integer err_count = 0, n_compared = 0, cycles = 0, n_sync = 0, i;
  integer seed = 32'hc8c1_3e90;
  logic [7:0] q, m;
  pmsr_ctrl dut (.clock_i, .rst_b_i, .spi_sen_b_i, .spi_sclk_i, .spi_sdi_i,
    .spi_sdo_o, .spi_sdo_oe_o, .sync_or_power_down_pin_i(pin),
    .reference_buffer_pin_i(refpin), .global_power_off_o, .bias_off_o,
    .clock_buffer_off_o, .diff_clock_buffer_off_o, .reference_amp_off_o,
    .bandgap_off_o, .sync_pulse_o, .ref_internal_o, .ref_ext_buffered_o,
    .ref_ext_direct_o, .single_ended_clock_select_o,
    .single_ended_analog_input_o, .delay_line_power_off_o,
    .auto_zero_enable_o);
  pmsr_spi_host host (.clock_i, .sdo_i(spi_sdo_o), .sen_b_o(spi_sen_b_i),
    .sclk_o(spi_sclk_i), .sdi_o(spi_sdi_i));
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  function automatic [7:0] exp_pd(input [7:0] mk);
    exp_pd = {4'h0, ~mk[5], ~mk[3], ~mk[2], mk[1]};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (sync_pulse_o === 1'b1) n_sync++;
    if (cycles == 20000) begin
      err_count++;
      results;
    end
  end
  initial begin
    repeat (2) @(negedge clock_i);
    rst_b_i = 1;
    host.xfer(1, 15'h000d, 8'h00, q); chk(q, 8'h00);
    host.xfer(1, 15'h000e, 8'h00, q); chk(q, 8'h00);
    host.xfer(1, 15'h0011, 8'h00, q); chk(q, 8'h00);
    host.xfer(0, 15'h0012, 8'h5a, q);
    host.xfer(1, 15'h0012, 8'h00, q); chk(q, 8'h00);
    for (i = 0; i < 8; i++) begin
      m = $random(seed) & 8'h2e;
      host.xfer(0, 15'h000d, m, q);
      host.xfer(0, 15'h0009, 8'h01, q);
      chk(global_power_off_o, 1);
      chk({bias_off_o, clock_buffer_off_o, reference_amp_off_o,
        bandgap_off_o}, exp_pd(m));
      host.xfer(1, 15'h000d, 8'h00, q); chk(q, m);
      host.xfer(0, 15'h0009, 8'h00, q);
      chk({bias_off_o, clock_buffer_off_o, reference_amp_off_o,
        bandgap_off_o, global_power_off_o}, 0);
      m = $random(seed) & 8'h25;
      host.xfer(0, 15'h0011, m, q);
      chk({single_ended_analog_input_o, delay_line_power_off_o,
        auto_zero_enable_o}, {m[5], m[2], m[0]});
      host.xfer(1, 15'h0011, 8'h00, q); chk(q, m);
    end
    pin = 1;
    repeat (2) @(negedge clock_i);
    chk(global_power_off_o, 1);
    pin = 0;
    host.xfer(0, 15'h000e, 8'h80, q);
    i = n_sync;
    pin = 1;
    repeat (3) @(negedge clock_i);
    chk(global_power_off_o, 0);
    chk(n_sync - i, 1);
    pin = 0;
    host.xfer(0, 15'h000e, 8'h20, q);
    i = n_sync;
    host.xfer(0, 15'h000e, 8'h60, q);
    host.xfer(1, 15'h000e, 8'h00, q); chk(q, 8'h60);
    host.xfer(0, 15'h000e, 8'h20, q);
    chk(n_sync - i, 2);
    host.xfer(0, 15'h000e, 8'h00, q);
    i = n_sync;
    host.xfer(0, 15'h000e, 8'h40, q);
    chk(n_sync - i, 0);
    host.xfer(0, 15'h000e, 8'ha0, q);
    i = n_sync;
    pin = 1;
    repeat (3) @(negedge clock_i);
    pin = 0;
    chk(n_sync - i, 0);
    for (i = 0; i < 2; i++) begin
      refpin = i[0];
      host.xfer(0, 15'h000e, 8'h01, q);
      chk({ref_internal_o, ref_ext_buffered_o, ref_ext_direct_o,
        single_ended_clock_select_o}, {~refpin, refpin, 2'b00});
    end
    for (i = 0; i < 8; i++) begin
      m = {4'h0, 1'b1, i[1:0], i[2]};
      host.xfer(0, 15'h000e, m, q);
      chk({ref_internal_o, ref_ext_buffered_o, ref_ext_direct_o},
        {i[1:0] == 0, i[1:0] == 1, i[1:0] == 2});
      chk({single_ended_clock_select_o, diff_clock_buffer_off_o},
        {2{i[2]}});
    end
    rst_b_i = 0;
    repeat (2) @(negedge clock_i);
    rst_b_i = 1;
    chk({ref_internal_o, ref_ext_buffered_o, single_ended_clock_select_o},
      {~refpin, refpin, 1'b0});
    host.xfer(1, 15'h000e, 8'h00, q); chk(q, 8'h00);
    results;
  end
endmodule
